// ---- design/pwm_serialiser.sv ----
// two-channel pwm / serialiser with shared word queue and apb registers
//
// Notes on behaviour
// - enable bit starts channel state machine; clearing it stops the channel
// - registers and queue accept writes regardless of any enable bit
// - mode bit zero gives modulation, one gives serial, over period length
// - serial mode shifts the word msb first, truncated or padded by period
// - mark/space bit in modulation mode replaces the spread pulse algorithm
// - mark/space bit has no influence in serial mode
// - repeat bit with queue source resends last fetched word while queue empty
// - repeat bit has no effect when the data register is the source
// - idle level drives the output whenever the channel is not sending
// - serial mode pads with idle level after data and between words
// - invert bit inverts the final output
// - source bit one takes words from queue, zero from data register
// - writing one to queue clear empties it at once; reads give zero
// - full and empty flags are live; empty reads one after reset
// - write to full queue sets sticky write error, cleared by writing one
// - read from empty queue sets sticky read error, cleared by writing one
// - gap flag set when queue runs empty between words unless repeating
// - bus error flag set when writes to one register come faster than synchroniser allows
// - busy bit per channel reads one while that channel transmits
// - shared queue holds eight words of 32 bits
// - modulation adds value to accumulator, outputs one and subtracts period
// - period resets to 32; data truncated or padded to period length
// - channels sharing the queue take successive words in turn
`timescale 1ns/100ps
module pwm_serialiser
   import pwm_pkg::*;
(
   input  wire logic                I_CLK,
   input  wire logic                I_RSTN,
   input  wire logic                I_PSEL,
   input  wire logic                I_PENABLE,
   input  wire logic                I_PWRITE,
   input  wire logic [ADDR_W-1:0]   I_PADDR,
   input  wire logic [DATA_W-1:0]   I_PWDATA,
   output logic      [DATA_W-1:0]   O_PRDATA,
   output logic                     O_PREADY,
   output logic      [NUM_CH-1:0]   O_PWM
);
   function automatic logic ctl_bit(input logic [15:0] c, input int ch, input int pos);
      return c[ch*CH_STRIDE+pos];
   endfunction

   logic [15:0]         control;
   logic [31:0]         dma_cfg;
   logic [DATA_W-1:0]   period [NUM_CH];
   logic [DATA_W-1:0]   value  [NUM_CH];
   logic [DATA_W-1:0]   q_mem  [Q_DEPTH];
   logic [Q_PTR_W-1:0]  wp;
   logic [Q_PTR_W-1:0]  rp;
   logic [Q_CNT_W-1:0]  q_cnt;
   logic                werr;
   logic                rerr;
   logic                bus_sync_error_flag;
   logic [NUM_CH-1:0]   gap;
   logic [2:0]          sync_cnt;
   logic [ADDR_W-1:0]   last_addr;
   logic                turn;
   chan_state_type      st     [NUM_CH];
   logic [DATA_W-1:0]   cnt    [NUM_CH];
   logic [DATA_W-1:0]   acc    [NUM_CH];
   logic [DATA_W-1:0]   word   [NUM_CH];
   logic [NUM_CH-1:0]   have;

   // one wait state: commit in the first access cycle, ready next cycle
   wire access   = I_PSEL & I_PENABLE & ~O_PREADY;
   wire wr       = access & I_PWRITE;
   wire wr_ctl   = wr & (I_PADDR == OFS_CONTROL);
   wire wr_flags = wr & (I_PADDR == OFS_FLAGS);
   wire wr_queue = wr & (I_PADDR == OFS_QUEUE);
   wire q_full   = (q_cnt == Q_CNT_W'(Q_DEPTH));
   wire q_empty  = (q_cnt == '0);
   wire q_clear  = wr_ctl & I_PWDATA[POS_QCLEAR];
   wire push     = wr_queue & ~q_full;
   wire [DATA_W-1:0] w1c  = wr_flags ? I_PWDATA : '0;
   wire [DATA_W-1:0] head = q_mem[rp];

   logic [NUM_CH-1:0] en, srl, rpt, idle, inv, useq, msp;
   logic [NUM_CH-1:0] at_edge, want, grant, gap_set, bit_out, busy;
   wire shared = &(en & useq);
   wire pop    = |grant;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         wire [32:0] sum     = {1'b0, acc[g]} + {1'b0, word[g]};
         wire        ge      = sum >= {1'b0, period[g]};
         wire [31:0] next_acc = ge ? 32'(sum - {1'b0, period[g]}) : sum[31:0];
         wire        last    = ({1'b0, cnt[g]} + 33'h1_0000_0001 - 33'h1_0000_0000)
                               >= {1'b0, period[g]};
         wire        ser_bit = (cnt[g] < 32'h0000_0020) ? word[g][5'd31 - cnt[g][4:0]]
                                                          : idle[g];
         wire        ms_bit  = cnt[g] < word[g];
         wire        mod_bit = msp[g] ? ms_bit : ge;
         assign en[g]   = ctl_bit(control, g, POS_ENABLE);
         assign srl[g]  = ctl_bit(control, g, POS_SERIAL);
         assign rpt[g]  = ctl_bit(control, g, POS_REPEAT);
         assign idle[g] = ctl_bit(control, g, POS_IDLE);
         assign inv[g]  = ctl_bit(control, g, POS_INVERT);
         assign useq[g] = ctl_bit(control, g, POS_USEQ);
         assign msp[g]  = ctl_bit(control, g, POS_MARKSP);
         assign busy[g] = (st[g] == ST_SEND);
         assign at_edge[g] = en[g] & (~busy[g] | last);
         assign want[g]    = at_edge[g] & useq[g];
         // lock step: a sharing channel waits until it is its turn
         assign grant[g]   = want[g] & ~q_empty & (~shared | (turn == 1'(g)));
         assign gap_set[g] = want[g] & q_empty & busy[g] & ~(rpt[g] & have[g]);
         assign bit_out[g] = srl[g] ? ser_bit : mod_bit;

         always_ff @(posedge I_CLK or negedge I_RSTN) begin
            if (!I_RSTN) begin
               st[g]   <= ST_OFF;
               cnt[g]  <= '0;
               acc[g]  <= '0;
               word[g] <= '0;
               have[g] <= 1'b0;
            end else if (!en[g]) begin
               st[g]   <= ST_OFF;
               cnt[g]  <= '0;
               acc[g]  <= '0;
               have[g] <= have[g] & ~q_clear;
            end else begin
               acc[g]  <= busy[g] ? next_acc : acc[g];
               cnt[g]  <= at_edge[g] ? '0 : cnt[g] + 32'h0000_0001;
               have[g] <= (have[g] & ~q_clear) | grant[g];
               if (at_edge[g]) begin
                  if (!useq[g]) begin
                     word[g] <= value[g];
                     st[g]   <= ST_SEND;
                  end else if (grant[g]) begin
                     word[g] <= head;
                     st[g]   <= ST_SEND;
                  end else if (q_empty && rpt[g] && have[g]) begin
                     st[g]   <= ST_SEND;
                  end else begin
                     st[g]   <= ST_WAIT;
                  end
               end
            end
         end

         always_ff @(posedge I_CLK or negedge I_RSTN) begin
            if (!I_RSTN) begin
               O_PWM[g] <= 1'b0;
               gap[g]   <= 1'b0;
            end else begin
               O_PWM[g] <= (busy[g] ? bit_out[g] : idle[g]) ^ inv[g];
               gap[g]   <= gap_set[g] | (gap[g] & ~w1c[POS_GAP+g]);
            end
         end
      end
   endgenerate

   always_ff @(posedge I_CLK) begin
      if (push) begin
         q_mem[wp] <= I_PWDATA;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         wp    <= '0;
         rp    <= '0;
         q_cnt <= '0;
         turn  <= 1'b0;
      end else if (q_clear) begin
         wp    <= '0;
         rp    <= '0;
         q_cnt <= '0;
         turn  <= 1'b0;
      end else begin
         wp    <= wp + Q_PTR_W'(push);
         rp    <= rp + Q_PTR_W'(pop);
         q_cnt <= q_cnt + Q_CNT_W'(push) - Q_CNT_W'(pop);
         turn  <= (shared & pop) ? grant[0] : turn;
      end
   end

   // sticky flags: a new event in the clearing cycle wins over the clear
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         werr      <= 1'b0;
         rerr      <= 1'b0;
         bus_sync_error_flag      <= 1'b0;
         sync_cnt  <= '0;
         last_addr <= '0;
      end else begin
         werr <= (wr_queue & q_full) | (werr & ~w1c[POS_WERR]);
         rerr <= (|gap_set) | (rerr & ~w1c[POS_RERR]);
         bus_sync_error_flag <= (wr & (sync_cnt != '0) & (I_PADDR == last_addr))
                 | (bus_sync_error_flag & ~w1c[POS_BUS_SYNC_ERROR_FLAG]);
         sync_cnt  <= wr ? SYNC_GAP_CYC : (sync_cnt - 3'(sync_cnt != '0));
         last_addr <= wr ? I_PADDR : last_addr;
      end
   end

   // register writes never look at the enable bits
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         control   <= '0;
         dma_cfg   <= DMA_RST;
         period[0] <= PERIOD_RST;
         period[1] <= PERIOD_RST;
         value[0]  <= WORD_RST;
         value[1]  <= WORD_RST;
      end else if (wr) begin
         case (I_PADDR)
            OFS_CONTROL: control   <= I_PWDATA[15:0] & CONTROL_MASK;
            OFS_DMA:     dma_cfg   <= I_PWDATA;
            OFS_PERIOD1: period[0] <= I_PWDATA;
            OFS_WORD1:   value[0]  <= I_PWDATA;
            OFS_PERIOD2: period[1] <= I_PWDATA;
            OFS_WORD2:   value[1]  <= I_PWDATA;
            default:     control   <= control;
         endcase
      end
   end

   wire [31:0] flags_word = {19'h0_0000, 2'b00, busy, bus_sync_error_flag, 2'b00, gap,
                             rerr, werr, q_empty, q_full};
   wire [31:0] rd_data =
      (I_PADDR == OFS_CONTROL) ? {16'h0000, control} :
      (I_PADDR == OFS_FLAGS)   ? flags_word :
      (I_PADDR == OFS_DMA)     ? dma_cfg :
      (I_PADDR == OFS_PERIOD1) ? period[0] :
      (I_PADDR == OFS_WORD1)   ? value[0] :
      (I_PADDR == OFS_PERIOD2) ? period[1] :
      (I_PADDR == OFS_WORD2)   ? value[1] : 32'h0000_0000;

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= '0;
      end else begin
         O_PREADY <= access;
         O_PRDATA <= (access & ~I_PWRITE) ? rd_data : '0;
      end
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);

   sequence s_clear_cmd;
      wr_ctl && I_PWDATA[POS_QCLEAR];
   endsequence
   sequence s_clear_done;
      q_empty && (q_cnt == '0) && O_PREADY ##1 !q_full;
   endsequence

   AST_CLEAR_EMPTIES: assert property (s_clear_cmd |=> s_clear_done)
      else $error("queue clear did not empty the queue");
   AST_START_SEND: assert property ($rose(en[0]) && !useq[0] |=> busy[0])
      else $error("enabled channel did not start sending");
   AST_STOP_IDLE: assert property (!en[0] ##1 !en[0] && $stable(control)
         |=> O_PWM[0] == ($past(idle[0]) ^ $past(inv[0])))
      else $error("stopped channel not at idle level");
   AST_WERR_SET: assert property (wr_queue && q_full |=> werr ##1 werr || $past(w1c[POS_WERR]))
      else $error("write to full queue not flagged");
   AST_WERR_HOLD: assert property (werr && !w1c[POS_WERR] |=> werr)
      else $error("write error flag lost without clear");
   AST_RERR_SET: assert property (|gap_set |=> rerr)
      else $error("read from empty queue not flagged");
   AST_GAP_SET: assert property (gap_set[0] |=> gap[0] && !busy[0])
      else $error("gap not flagged or channel still busy");
   AST_BUS_SYNC_ERROR_FLAG_FAST: assert property (wr ##1 !wr [*2] ##1 (wr && I_PADDR == last_addr) |=> bus_sync_error_flag)
      else $error("fast write not flagged as bus error");
   AST_SERIAL_MSB: assert property (busy[0] && srl[0] && cnt[0] == '0 && $stable(control)
         |=> O_PWM[0] == ($past(word[0][31]) ^ $past(inv[0])))
      else $error("serial output did not start with msb");
   AST_MARK_SPACE: assert property (busy[0] && !srl[0] && msp[0] && $stable(control)
         |=> O_PWM[0] == (($past(cnt[0]) < $past(word[0])) ^ $past(inv[0])))
      else $error("mark space output wrong");
   AST_LOCK_STEP: assert property (shared && grant[0] && !q_clear |=> !grant[0] && turn)
      else $error("sharing channels did not alternate");
endmodule

// ---- design/pwm_pkg.sv ----
// constants, register map and types for the two-channel pwm / serialiser
package pwm_pkg;
   localparam int unsigned NUM_CH    = 2;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned Q_DEPTH   = 8;
   localparam int unsigned Q_PTR_W   = 3;
   localparam int unsigned Q_CNT_W   = 4;
   localparam int unsigned ADDR_W    = 8;

   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_FLAGS   = 8'h04;
   localparam logic [7:0] OFS_DMA     = 8'h08;
   localparam logic [7:0] OFS_PERIOD1 = 8'h10;
   localparam logic [7:0] OFS_WORD1   = 8'h14;
   localparam logic [7:0] OFS_QUEUE   = 8'h18;
   localparam logic [7:0] OFS_PERIOD2 = 8'h20;
   localparam logic [7:0] OFS_WORD2   = 8'h24;

   // control field positions inside one channel's byte
   localparam int unsigned CH_STRIDE   = 8;
   localparam int unsigned POS_ENABLE  = 0;
   localparam int unsigned POS_SERIAL  = 1;
   localparam int unsigned POS_REPEAT  = 2;
   localparam int unsigned POS_IDLE    = 3;
   localparam int unsigned POS_INVERT  = 4;
   localparam int unsigned POS_USEQ    = 5;
   localparam int unsigned POS_QCLEAR  = 6;
   localparam int unsigned POS_MARKSP  = 7;
   localparam logic [15:0] CONTROL_MASK = 16'hbfbf;

   // flag register positions
   localparam int unsigned POS_FULL  = 0;
   localparam int unsigned POS_EMPTY = 1;
   localparam int unsigned POS_WERR  = 2;
   localparam int unsigned POS_RERR  = 3;
   localparam int unsigned POS_GAP   = 4;
   localparam int unsigned POS_BUS_SYNC_ERROR_FLAG  = 8;
   localparam int unsigned POS_BUSY  = 9;

   localparam logic [31:0] PERIOD_RST = 32'h0000_0020;
   localparam logic [31:0] DMA_RST    = 32'h0000_0707;
   localparam logic [31:0] WORD_RST   = 32'h0000_0000;

   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned SYNC_GAP_NS   = 100;
   localparam logic [2:0]  SYNC_GAP_CYC  =
      3'((SYNC_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_WAIT = 3'b010,
      ST_SEND = 3'b100
   } chan_state_type;
endpackage

// ---- verification/apb_host.sv ----
// software-side register port model for the pwm block
`timescale 1ns/100ps
module apb_host
   import pwm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [DATA_W-1:0] prdata,
   input  wire logic              pready,
   output logic                   psel,
   output logic                   penable,
   output logic                   pwrite,
   output logic [ADDR_W-1:0]      paddr,
   output logic [DATA_W-1:0]      pwdata
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
   end

   // called just after an edge; idle 0 keeps select up for a back-to-back transfer
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input int idle,
                       output logic [DATA_W-1:0] q);
      int n;
      n = 0;
      if (psel !== 1'b1) psel = 1'b1;
      pwrite = wr;
      paddr  = a;
      pwdata = d;
      @(posedge clk);
      #1;
      penable = 1'b1;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      // hold the request through the edge at which ready is sampled high
      @(posedge clk);
      #1;
      penable = 1'b0;
      // released data changes so a stale value is never mistaken for a live one
      pwdata = ~pwdata;
      if (idle > 0) begin
         psel = 1'b0;
         repeat (idle) @(posedge clk);
         #1;
      end
   endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the two-channel pwm / serialiser
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
   import pwm_pkg::*;
;
   logic              I_CLK;
   logic              I_RSTN;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] O_PRDATA;
   logic              O_PREADY;
   logic [NUM_CH-1:0] O_PWM;
   int                fails;
   int                n_compared;
   int                cyc;
   logic [31:0]       q[$];
   logic [31:0]       w;
   logic [23:0]       s0;
   logic [23:0]       s1;
   logic [1:0]        hits;

   pwm_serialiser dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(O_PRDATA),
      .O_PREADY(O_PREADY), .O_PWM(O_PWM));
   apb_host host (.clk(I_CLK), .prdata(O_PRDATA), .pready(O_PREADY), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   initial begin
      I_CLK = 1'b0;
      forever #12.5 I_CLK = ~I_CLK;
   end

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // hang guard: the whole sequence needs just over a thousand cycles
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input int idle = 2);
      logic [31:0] r;
      host.xfer(1'b1, a, d, idle, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      host.xfer(1'b0, a, 32'h0000_0000, 2, r);
      `CHK(r, e)
   endtask

   // mode 0 spread algorithm, 1 serial, 2 mark/space; stream compared at any phase
   task automatic run_pat(input int ch, input int mode, input int p, input logic [31:0] wd,
                          input logic idl, input logic inv, input logic ms);
      logic pat[$];
      logic s[$];
      int   acc;
      logic b;
      logic hit;
      logic ok;
      logic [7:0] cb;
      acc = 0;
      for (int i = 0; i < p; i++) begin
         if (mode == 0) begin
            acc = acc + int'(wd);
            b = (acc >= p);
            if (b) acc = acc - p;
         end else if (mode == 1) b = (i < 32) ? wd[31 - i] : idl;
         else b = (i < int'(wd));
         pat.push_back(b ^ inv);
      end
      cb = 8'(1 | ((mode == 1) << POS_SERIAL) | (idl << POS_IDLE) | (inv << POS_INVERT)
         | (ms << POS_MARKSP));
      wr(OFS_PERIOD1 + 8'(16 * ch), 32'(p));
      wr(OFS_WORD1 + 8'(16 * ch), wd);
      wr(OFS_CONTROL, 32'(cb) << (8 * ch));
      repeat (12) @(posedge I_CLK);
      for (int i = 0; i < 3 * p; i++) begin
         @(posedge I_CLK);
         #1;
         s.push_back(O_PWM[ch]);
      end
      hit = 1'b0;
      for (int r = 0; r < p; r++) begin
         ok = 1'b1;
         for (int i = 0; i < 3 * p; i++) if (s[i] !== pat[(i + r) % p]) ok = 1'b0;
         if (ok) hit = 1'b1;
      end
      `CHK(hit, 1'b1)
      #1;
      rd_chk(OFS_FLAGS, 32'h0000_0002 | (32'h1 << (POS_BUSY + ch)));
      wr(OFS_CONTROL, 32'(cb & 8'hfe) << (8 * ch));
      repeat (3) @(posedge I_CLK);
      #1;
      `CHK(O_PWM[ch], idl ^ inv)
      #1;
      $display("pattern test ch%0d mode %0d done", ch, mode);
   endtask

   initial begin
      fails = 0;
      n_compared = 0;
      cyc = 0;
      I_RSTN = 1'b0;
      void'($urandom(7288));
      repeat (6) @(posedge I_CLK);
      #1;
      I_RSTN = 1'b1;
      rd_chk(OFS_CONTROL, 32'h0000_0000);
      rd_chk(OFS_FLAGS, 32'h0000_0002);
      rd_chk(OFS_DMA, DMA_RST);
      rd_chk(OFS_PERIOD1, 32'h0000_0020);
      rd_chk(OFS_PERIOD2, 32'h0000_0020);
      rd_chk(OFS_WORD2, 32'h0000_0000);
      rd_chk(OFS_QUEUE, 32'h0000_0000);
      rd_chk(8'h0c, 32'h0000_0000);
      $display("reset test done");
      for (int ch = 0; ch < 2; ch++) begin
         run_pat(ch, 1, 8, $urandom, 1'b0, 1'b0, 1'b1);
         run_pat(ch, 1, 40, $urandom, 1'b1, 1'b0, 1'b0);
         run_pat(ch, 0, 16, $urandom % 16, 1'b0, 1'b1, 1'b0);
         run_pat(ch, 2, 12, $urandom % 12, 1'b1, 1'b0, 1'b1);
      end
      w = $urandom & 32'(CONTROL_MASK) & 32'hfefe; // reserved bits left zero
      wr(OFS_CONTROL, w | 32'h0000_0040);
      rd_chk(OFS_CONTROL, w);
      wr(OFS_CONTROL, 32'h0000_0000);
      for (int i = 0; i < 9; i++) begin
         w = $urandom;
         wr(OFS_QUEUE, w);
         if (q.size() < Q_DEPTH) q.push_back(w);
      end
      rd_chk(OFS_FLAGS, 32'(q.size() == 8) | 32'h0000_0004);
      wr(OFS_FLAGS, 32'h0000_0000);
      rd_chk(OFS_FLAGS, 32'h0000_0005);
      wr(OFS_FLAGS, 32'h0000_0004);
      wr(OFS_CONTROL, 32'h0000_0040);
      q.delete();
      rd_chk(OFS_FLAGS, 32'(q.size() == 0) << POS_EMPTY);
      $display("queue test done");
      wr(OFS_PERIOD1, 32'h0000_0008);
      wr(OFS_QUEUE, $urandom);
      wr(OFS_CONTROL, 32'h0000_0023);
      repeat (40) @(posedge I_CLK);
      #1;
      rd_chk(OFS_FLAGS, 32'h0000_001a);
      `CHK(O_PWM[0], 1'b0)
      #1;
      wr(OFS_CONTROL, 32'h0000_0000);
      wr(OFS_FLAGS, 32'h0000_0018);
      wr(OFS_QUEUE, $urandom);
      wr(OFS_CONTROL, 32'h0000_0027);
      repeat (40) @(posedge I_CLK);
      #1;
      rd_chk(OFS_FLAGS, 32'h0000_0202);
      wr(OFS_CONTROL, 32'h0000_0000);
      $display("gap test done");
      wr(OFS_CONTROL, 32'h0000_0040);
      wr(OFS_PERIOD2, 32'h0000_0008);
      q.delete();
      for (int i = 0; i < 2; i++) begin
         q.push_back($urandom);
         wr(OFS_QUEUE, q[i]);
      end
      wr(OFS_CONTROL, 32'h0000_2323, 0);
      s0 = '0;
      s1 = '0;
      for (int i = 0; i < 24; i++) begin
         @(posedge I_CLK);
         #1;
         s0 = {s0[22:0], O_PWM[0]};
         s1 = {s1[22:0], O_PWM[1]};
      end
      hits = 2'b00;
      for (int r = 0; r <= 16; r++) begin
         if (s0[r+:8] == q[0][31:24]) hits[0] = 1'b1;
         if (s1[r+:8] == q[1][31:24]) hits[1] = 1'b1;
      end
      `CHK(hits, 2'b11)
      rd_chk(OFS_FLAGS, 32'h0000_003a);
      wr(OFS_CONTROL, 32'h0000_0000);
      wr(OFS_FLAGS, 32'h0000_0038);
      $display("lock step test done");
      w = $urandom;
      wr(OFS_WORD2, ~w, 0);
      wr(OFS_WORD2, w);
      rd_chk(OFS_FLAGS, 32'h0000_0102);
      rd_chk(OFS_WORD2, w);
      wr(OFS_FLAGS, 32'h0000_0100);
      rd_chk(OFS_FLAGS, 32'h0000_0002);
      $display("bus error test done");
      wrap_up();
   end
endmodule
